// ### pkg/cpc_defines.svh
`ifndef CPC_DEFINES_SVH
`define CPC_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CPC_ADDR_W 12
`define CPC_CORE_PATH_CONTROL_OFFSET 12'h000
`define CPC_CORE_PATH_CONTROL_RESET 16'h049C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CPC_DC_TRIM_FIRST_BIT 15
`define CPC_DC_TRIM_SECOND_BIT 14
`define CPC_PHASE_GAIN_FIRST_BIT 13
`define CPC_PHASE_GAIN_SECOND_BIT 12
`define CPC_INTERP_MSB 11
`define CPC_INTERP_LSB 8
`define CPC_ELASTIC_BUF_BIT 7
`define CPC_RSVD_MSB 6
`define CPC_RSVD_LSB 5
`define CPC_ALARM_DRIVE_BIT 4
`define CPC_ALARM_POL_BIT 3
`define CPC_CLKDIV_SYNC_BIT 2
`define CPC_DROOP_FIRST_BIT 1
`define CPC_DROOP_SECOND_BIT 0

// ----------------------------------------------------------------
// interpolation codes
// ----------------------------------------------------------------
`define CPC_INTERP_X1 4'h0
`define CPC_INTERP_X2 4'h1
`define CPC_INTERP_X4 4'h2
`define CPC_INTERP_X8 4'h4
`define CPC_INTERP_X16 4'h8

`endif

// ### pkg/cpc_pkg.sv
package cpc_pkg;

  // ----------------------------------------------------------------
  // control word, bit 15 first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic iq_dc_trim_first_pair_enable;
    logic iq_dc_trim_second_pair_enable;
    logic iq_phase_gain_first_pair_enable;
    logic iq_phase_gain_second_pair_enable;
    logic [3:0] interp_code;
    logic elastic_buffer_enable;
    logic [1:0] reserved;
    logic alarm_drive_enable;
    logic alarm_positive_logic;
    logic clkdiv_sync_enable;
    logic droop_comp_first_pair_enable;
    logic droop_comp_second_pair_enable;
  } cpc_ctrl_t;

  // ----------------------------------------------------------------
  // decoded interpolation ratio (log2)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CPC_RATIO_X1 = 3'b000,
    CPC_RATIO_X2 = 3'b001,
    CPC_RATIO_X4 = 3'b010,
    CPC_RATIO_X8 = 3'b011,
    CPC_RATIO_X16 = 3'b100
  } cpc_ratio_t;

  // ----------------------------------------------------------------
  // alarm pin as two signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pin_out;
    logic pin_oe;
  } cpc_alarm_pin_t;

endpackage

// ### hw/cpc_core_path_control.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "cpc_defines.svh"

module cpc_core_path_control (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // control to data paths
  output cpc_pkg::cpc_ctrl_t ctrl,
  output cpc_pkg::cpc_ratio_t interp_ratio,
  output logic interp_code_illegal,
  output logic elastic_buffer_bypass,
  // alarm
  input wire logic alarm_event,
  output cpc_pkg::cpc_alarm_pin_t alarm_pin,
  // divided clock sync
  input wire logic sync_source_pulse,
  output logic clkdiv_sync_pulse,
  output logic buffer_out_ptr_sync
);
  import cpc_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire addr_hit = (paddr == `CPC_CORE_PATH_CONTROL_OFFSET);
  wire setup_phase = psel && !penable;
  wire access_phase = psel && penable;
  wire wr_commit = access_phase && pwrite && addr_hit;
  wire [1:0] lane_we = pstrb[1:0];

  assign pready = penable;
  assign pslverr = access_phase && !addr_hit;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  cpc_ctrl_t ctrl_reg;
  cpc_ctrl_t ctrl_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  wire [15:0] ctrl_bits = ctrl_reg;
  wire [15:0] merged_bits = {
    lane_we[1] ? pwdata[15:8] : ctrl_bits[15:8],
    lane_we[0] ? pwdata[7:0] : ctrl_bits[7:0]
  };

  assign ctrl_next = wr_commit ? cpc_ctrl_t'(merged_bits) : ctrl_reg;
  // reads sampled at setup, unmapped reads as zero
  assign prdata_next = (setup_phase && !pwrite) ?
                       (addr_hit ? {16'h0000, ctrl_bits} : 32'h0000_0000) : prdata_reg;

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg <= cpc_ctrl_t'(`CPC_CORE_PATH_CONTROL_RESET);
      prdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign ctrl = ctrl_reg;

  // ----------------------------------------------------------------
  // interpolation decode
  // ----------------------------------------------------------------
  cpc_ratio_t ratio_decoded;
  logic code_bad;

  always_comb begin
    ratio_decoded = CPC_RATIO_X1;
    code_bad = 1'b0;
    case (ctrl_reg.interp_code)
      `CPC_INTERP_X1: ratio_decoded = CPC_RATIO_X1;
      `CPC_INTERP_X2: ratio_decoded = CPC_RATIO_X2;
      `CPC_INTERP_X4: ratio_decoded = CPC_RATIO_X4;
      `CPC_INTERP_X8: ratio_decoded = CPC_RATIO_X8;
      `CPC_INTERP_X16: ratio_decoded = CPC_RATIO_X16;
      default: code_bad = 1'b1;
    endcase
  end

  assign interp_ratio = ratio_decoded;
  assign interp_code_illegal = code_bad;

  assign elastic_buffer_bypass = !ctrl_reg.elastic_buffer_enable;

  // ----------------------------------------------------------------
  // alarm pin
  // ----------------------------------------------------------------
  logic alarm_level_reg;
  logic alarm_level_next;

  assign alarm_level_next = ctrl_reg.alarm_positive_logic ? alarm_event : !alarm_event;

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      alarm_level_reg <= 1'b0;
    end else begin
      alarm_level_reg <= alarm_level_next;
    end
  end

  assign alarm_pin.pin_out = alarm_level_reg;
  assign alarm_pin.pin_oe = ctrl_reg.alarm_drive_enable;

  // ----------------------------------------------------------------
  // divided clock sync
  // ----------------------------------------------------------------
  logic sync_reg;
  logic sync_next;

  assign sync_next = sync_source_pulse && ctrl_reg.clkdiv_sync_enable;

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sync_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign clkdiv_sync_pulse = sync_reg;
  assign buffer_out_ptr_sync = sync_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_reg);

  sequence full_write_s;
    psel && penable && pwrite && addr_hit && (pstrb[1:0] == 2'b11);
  endsequence

  sequence read_setup_s;
    psel && !penable && !pwrite && addr_hit;
  endsequence

  sequence reg_write_s;
    psel && penable && pwrite && addr_hit;
  endsequence

  dc_trim_first_a: assert property (
    full_write_s |=> ctrl.iq_dc_trim_first_pair_enable == $past(pwdata[15]))
    else $error("first pair dc trim enable not loaded");

  dc_trim_second_a: assert property (
    full_write_s |=> ctrl.iq_dc_trim_second_pair_enable == $past(pwdata[14]))
    else $error("second pair dc trim enable not loaded");

  phase_gain_first_a: assert property (
    full_write_s |=> ctrl.iq_phase_gain_first_pair_enable == $past(pwdata[13]))
    else $error("first pair phase gain enable not loaded");

  phase_gain_second_a: assert property (
    full_write_s |=> ctrl.iq_phase_gain_second_pair_enable == $past(pwdata[12]))
    else $error("second pair phase gain enable not loaded");

  interp_decode_a: assert property (
    (full_write_s and (pwdata[11:8] == 4'h8)) |=>
      interp_ratio == CPC_RATIO_X16 && !interp_code_illegal)
    else $error("sixteen times code not decoded");

  buffer_bypass_a: assert property (
    (full_write_s and !pwdata[7]) |=> elastic_buffer_bypass)
    else $error("buffer not bypassed after disable");

  alarm_release_a: assert property (
    (reg_write_s and (pstrb[0] && !pwdata[4])) |=> !alarm_pin.pin_oe)
    else $error("alarm pin driven while drive disabled");

  alarm_held_off_a: assert property (
    (!alarm_pin.pin_oe && !(psel && penable && pwrite && addr_hit)) |=> !alarm_pin.pin_oe)
    else $error("alarm pin drive came back without a write");

  alarm_drive_a: assert property (
    (reg_write_s and (pstrb[0] && pwdata[4])) |=> alarm_pin.pin_oe)
    else $error("alarm pin not driven after drive enable");

  alarm_polarity_a: assert property (
    (!ctrl.alarm_positive_logic && $stable(ctrl.alarm_positive_logic)) ##0 alarm_event
      |=> !alarm_pin.pin_out || $changed(ctrl.alarm_positive_logic))
    else $error("negative logic alarm not low");

  sync_gate_a: assert property (
    (sync_source_pulse && !ctrl.clkdiv_sync_enable) |=> !clkdiv_sync_pulse)
    else $error("sync passed while disabled");

  droop_filters_a: assert property (
    full_write_s |=> ctrl.droop_comp_first_pair_enable == $past(pwdata[1]) &&
      ctrl.droop_comp_second_pair_enable == $past(pwdata[0]))
    else $error("droop enables not loaded");

  read_back_a: assert property (
    read_setup_s ##1 (psel && penable) |-> prdata == {16'h0000, $past(ctrl_bits)})
    else $error("read data does not match register");

  alarm_positive_a: assert property (
    (ctrl.alarm_positive_logic && $stable(ctrl.alarm_positive_logic)) ##0 alarm_event
      |=> alarm_pin.pin_out || $changed(ctrl.alarm_positive_logic))
    else $error("positive logic alarm not high");

  alarm_idle_neg_a: assert property (
    (!ctrl.alarm_positive_logic && $stable(ctrl.alarm_positive_logic)) ##0 !alarm_event
      |=> alarm_pin.pin_out || $changed(ctrl.alarm_positive_logic))
    else $error("negative logic idle alarm not high");

  sync_pass_a: assert property (
    (sync_source_pulse && ctrl.clkdiv_sync_enable) |=>
      clkdiv_sync_pulse && buffer_out_ptr_sync)
    else $error("enabled sync not passed");

  sync_idle_a: assert property (
    !sync_source_pulse |=> !clkdiv_sync_pulse && !buffer_out_ptr_sync)
    else $error("sync pulse without source");

  buffer_used_a: assert property (
    (full_write_s and pwdata[7]) |=> !elastic_buffer_bypass)
    else $error("buffer bypassed while enabled");

  interp_x1_a: assert property (
    (full_write_s and (pwdata[11:8] == 4'h0)) |=>
      interp_ratio == CPC_RATIO_X1 && !interp_code_illegal)
    else $error("one times code not decoded");

  interp_x2_a: assert property (
    (full_write_s and (pwdata[11:8] == 4'h1)) |=>
      interp_ratio == CPC_RATIO_X2 && !interp_code_illegal)
    else $error("two times code not decoded");

  interp_x4_a: assert property (
    (full_write_s and (pwdata[11:8] == 4'h2)) |=>
      interp_ratio == CPC_RATIO_X4 && !interp_code_illegal)
    else $error("four times code not decoded");

  interp_x8_a: assert property (
    (full_write_s and (pwdata[11:8] == 4'h4)) |=>
      interp_ratio == CPC_RATIO_X8 && !interp_code_illegal)
    else $error("eight times code not decoded");

  interp_bad_a: assert property (
    (full_write_s and (pwdata[11:8] == 4'h3)) |=> interp_code_illegal)
    else $error("illegal interpolation code not flagged");

  lane_keep_high_a: assert property (
    (reg_write_s and !pstrb[1]) |=> ctrl_bits[15:8] == $past(ctrl_bits[15:8]))
    else $error("upper byte changed with its strobe off");

  lane_keep_low_a: assert property (
    (reg_write_s and !pstrb[0]) |=> ctrl_bits[7:0] == $past(ctrl_bits[7:0]))
    else $error("lower byte changed with its strobe off");

  unmapped_write_a: assert property (
    (psel && penable && pwrite && !addr_hit) |=> $stable(ctrl_bits))
    else $error("register changed by unmapped write");

  unmapped_read_a: assert property (
    (psel && !penable && !pwrite && !addr_hit) ##1 (psel && penable) |-> prdata == 32'h0)
    else $error("unmapped read not zero");

  zero_wait_a: assert property (
    (psel && penable) |-> pready)
    else $error("access phase without ready");

  slverr_flag_a: assert property (
    (psel && penable && !addr_hit) |-> pslverr)
    else $error("unmapped access without error");

endmodule

// ### test/cpc_core_path_control_tb_top.sv
`timescale 1ns/1ps
`include "cpc_defines.svh"

module cpc_core_path_control_tb_top;
  import cpc_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`CPC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic alarm_event = 1'b0;
  logic sync_source_pulse = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, illegal, bypass, dsync, psync;
  cpc_ctrl_t ctrl;
  cpc_ratio_t ratio;
  cpc_alarm_pin_t alarm_pin;
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic er;

  cpc_core_path_control uut (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ctrl(ctrl), .interp_ratio(ratio), .interp_code_illegal(illegal),
    .elastic_buffer_bypass(bypass), .alarm_event(alarm_event), .alarm_pin(alarm_pin),
    .sync_source_pulse(sync_source_pulse), .clkdiv_sync_pulse(dsync),
    .buffer_out_ptr_sync(psync)
  );

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      print_verdict();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("ctrl", 32'(ctrl), 32'h049C);
    chk("ratio", 32'(ratio), 32'(CPC_RATIO_X8));
    chk("bypass", 32'(bypass), 32'h0);
    chk("oe", 32'(alarm_pin.pin_oe), 32'h1);
    apb(1'b0, 12'h000, 32'h0, 4'hF);
    chk("read", rd, 32'h049C);
  endtask

  task automatic t_bits();
    for (int i = 0; i < 16; i++) begin
      if (i == 5 || i == 6) continue;
      apb(1'b1, 12'h000, 32'h1 << i, 4'hF);
      chk("bit", 32'(ctrl), 32'h1 << i);
      chk("bypass", 32'(bypass), 32'(i != 7));
      chk("oe", 32'(alarm_pin.pin_oe), 32'(i == 4));
      apb(1'b0, 12'h000, 32'h0, 4'hF);
      chk("readback", rd, 32'h1 << i);
    end
  endtask

  task automatic t_interp();
    logic [3:0] code [6] = '{`CPC_INTERP_X1, `CPC_INTERP_X2, `CPC_INTERP_X4,
                             `CPC_INTERP_X8, `CPC_INTERP_X16, 4'h3};
    cpc_ratio_t exp [6] = '{CPC_RATIO_X1, CPC_RATIO_X2, CPC_RATIO_X4, CPC_RATIO_X8,
                            CPC_RATIO_X16, CPC_RATIO_X1};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'h000, {20'h0, code[i], 8'h0}, 4'hF);
      chk("ratio", 32'(ratio), 32'(exp[i]));
      chk("illegal", 32'(illegal), 32'(i == 5));
    end
  endtask

  task automatic t_alarm();
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, 12'h000, 32'h10 | (32'(p) << 3), 4'hF);
      for (int e = 0; e < 2; e++) begin
        @(posedge sys_clk);
        alarm_event <= e[0];
        @(posedge sys_clk);
        #1;
        chk("alarm", 32'(alarm_pin.pin_out), 32'(p[0] ? e[0] : !e[0]));
      end
    end
    apb(1'b1, 12'h000, 32'h0008, 4'hF);
    chk("oe off", 32'(alarm_pin.pin_oe), 32'h0);
  endtask

  task automatic t_sync();
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, 12'h000, 32'(s) << 2, 4'hF);
      sync_source_pulse <= 1'b1;
      @(posedge sys_clk);
      sync_source_pulse <= 1'b0;
      #1;
      chk("div sync", 32'(dsync), 32'(s));
      chk("ptr sync", 32'(psync), 32'(s));
      @(posedge sys_clk);
      #1;
      chk("sync end", 32'({dsync, psync}), 32'h0);
    end
  endtask

  task automatic t_refuse();
    apb(1'b1, 12'h000, 32'hFF9F, 4'hF);
    apb(1'b1, 12'h004, 32'h0, 4'hF);
    chk("err", 32'(er), 32'h1);
    chk("kept", 32'(ctrl), 32'hFF9F);
    apb(1'b0, 12'h004, 32'h0, 4'hF);
    chk("bad rd", rd, 32'h0);
    apb(1'b1, 12'h000, 32'h0, 4'h1);
    chk("lane", 32'(ctrl), 32'hFF00);
    apb(1'b1, 12'h000, 32'h1299, 4'h2);
    chk("lane hi", 32'(ctrl), 32'h1200);
  endtask

  task automatic t_rereset();
    nrst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("ctrl in rst", 32'(ctrl), 32'h049C);
    chk("pin in rst", 32'(alarm_pin.pin_out), 32'h0);
    @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("oe after rst", 32'(alarm_pin.pin_oe), 32'h1);
    apb(1'b0, 12'h000, 32'h0, 4'hF);
    chk("read after rst", rd, 32'h049C);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_bits();
    t_interp();
    t_alarm();
    t_sync();
    t_refuse();
    t_rereset();
    print_verdict();
  end
endmodule
